// [hw/mcsync_pkg.sv]
package mcsync_pkg;

	// ---------------------------------------------------------------
	// register map (word index on the register port)
	// ---------------------------------------------------------------
	localparam logic [4:0]  ADDR_MODE    = 5'h01;
	localparam logic [4:0]  ADDR_TIMING  = 5'h03;
	localparam logic [4:0]  ADDR_STATUS  = 5'h09;

	// sync_mode_config fields
	localparam int          MODE_PN_EN   = 13;
	localparam int          MODE_SEL     = 12;
	localparam int          MODE_PULSE   = 11;

	// sync_timing_config fields
	localparam int          TIM_THR_LSB  = 27;
	localparam int          TIM_IN_EN    = 26;
	localparam int          TIM_OUT_EN   = 25;
	localparam int          TIM_IDLY_LSB = 19;
	localparam int          TIM_ODLY_LSB = 11;
	localparam int          TIM_OPOL     = 9;
	localparam int          TIM_CST_LSB  = 4;

	// fault_and_lock_status fields
	localparam int          ST_SYNC_EN   = 0;
	localparam int          ST_DATA_EN   = 1;
	localparam int          ST_SYNC_FLG  = 6;
	localparam int          ST_DATA_FLG  = 7;
	localparam int          ST_LOCK      = 10;
	localparam int          ST_LOST      = 11;
	localparam int          ST_CLR_LOCK  = 12;

	// reset values
	localparam logic [31:0] MODE_RST     = 32'h0000_0000;
	localparam logic [31:0] TIMING_RST   = 32'h8000_0000;
	localparam logic [1:0]  IRQ_EN_RST   = 2'h3;

	// ---------------------------------------------------------------
	// code and timing
	// ---------------------------------------------------------------
	localparam int          CODE_LEN     = 32;
	localparam logic [31:0] PN_CODE      = 32'hB3A1_6E4D;
	localparam logic [6:0]  CORR_BASE    = 7'h20;
	localparam logic [5:0]  FRAME_LEN    = 6'h20;

	typedef enum logic [1:0] {
		LK_SEARCH = 2'b01,
		LK_LOCKED = 2'b10
	} mcsync_lock_t;

endpackage

// [hw/mcsync_corr_if.sv]
`timescale 1ns/1ps
interface mcsync_corr_if;
	logic       rx_bit;
	logic       sample_en;
	logic [4:0] threshold;
	logic       detect;

	modport host (output rx_bit, output sample_en, output threshold, input detect);
	modport corr (input rx_bit, input sample_en, input threshold, output detect);
endinterface

// [hw/mcsync_corr.sv]
`timescale 1ns/1ps
module mcsync_corr (
	input  wire logic    core_clk,
	input  wire logic    rst,
	mcsync_corr_if.corr  cif
);

	typedef struct packed {
		logic [31:0] shift;
		logic        detect;
	} mcsync_corr_st_t;

	mcsync_corr_st_t st_reg;
	mcsync_corr_st_t st_next;
	logic [31:0]     agree;
	logic [6:0]      match_cnt;

	// ---------------------------------------------------------------
	// per-bit agreement with the expected code
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < mcsync_pkg::CODE_LEN; gi++) begin : g_cmp
			assign agree[gi] = ~(st_reg.shift[gi] ^ mcsync_pkg::PN_CODE[gi]);
		end
	endgenerate

	always_comb begin
		match_cnt = 7'h00;
		for (int i = 0; i < mcsync_pkg::CODE_LEN; i++) begin
			match_cnt = match_cnt + {6'h00, agree[i]};
		end
	end

	always_comb begin
		st_next        = st_reg;
		st_next.detect = 1'b0;
		if (cif.sample_en) begin
			st_next.shift = {st_reg.shift[30:0], cif.rx_bit};
		end
		// match beats threshold
		// agreement (matches minus misses) must exceed the threshold, so a
		// larger threshold tolerates fewer bit errors
		if (cif.sample_en && ({match_cnt[5:0], 1'b0} > mcsync_pkg::CORR_BASE
			+ {2'h0, cif.threshold})) begin
			st_next.detect = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cif.detect = st_reg.detect;

endmodule

// [hw/mcsync_top.sv]
`timescale 1ns/1ps
// Operation
// - master sends the spread code on its sync output pair, looped to all.
// - receiver correlates its sync input and pulses once per valid code.
// - detected code aligns the clock state machine, and at acquisition the oscillator accumulator.
// - five-bit correlation threshold sits at bits 31:27 of timing config.
// - higher threshold needs closer match for lock; lower relaxes it.
// - status bit 10 reads one once synchronisation is achieved.
// - sticky lock-lost bit 11, cleared by writing bit 12 one then zero.
// - master output delay field 15:11 trims outgoing code in 80 ps steps.
// - master polarity bit 9 delays outgoing code by half a sample period.
// - input delay field 23:19 trims incoming sampling in 80 ps steps.
// - interrupt line is open-drain, active low, wire-OR capable.
// - data or sync timing error flag asserts the interrupt by default.
// - each error flag can be masked from the interrupt separately.
// - error flags latch until software writes one to them.
// - init pulse loads the 32-state clock machine with the preset 7:4.
// - init pulse lasts one cycle and recurs every 32 cycles.
// - slaves take the master phase from the code and set their accumulators.
module mcsync_top (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [4:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic        sync_in_p,
	input  wire logic        sync_in_n,
	output logic             sync_out_p,
	output logic             sync_out_n,
	output logic             sync_out_half_delay,
	output logic      [4:0]  sync_out_delay_trim,
	output logic      [4:0]  sync_in_delay_trim,
	input  wire logic        data_timing_err,
	input  wire logic        sync_timing_err,
	input  wire logic [31:0] nco_step,
	output logic      [31:0] nco_phase,
	output logic      [4:0]  clk_state,
	output logic             init_pulse,
	output logic             irq_n_o,
	output logic             irq_n_oe
);

	typedef struct packed {
		logic [31:0]          mode;
		logic [31:0]          timing;
		logic [1:0]           irq_en;
		logic                 sync_flag;
		logic                 data_flag;
		logic                 clr_lock;
		mcsync_pkg::mcsync_lock_t lock;
		logic                 lost;
		logic [5:0]           gap_cnt;
		logic [4:0]           tx_idx;
		logic                 tx_bit;
		logic [4:0]           clk_state;
		logic [31:0]          nco_acc;
		logic                 init;
		logic                 irq_oe;
		logic [31:0]          rdata;
	} mcsync_top_st_t;

	mcsync_top_st_t st_reg;
	mcsync_top_st_t st_next;
	mcsync_corr_if  cif ();
	logic           pn_mode;
	logic           rx_en;
	logic           tx_en;
	logic           wr_mode;
	logic           wr_timing;
	logic           wr_status;
	logic [31:0]    status_word;

	mcsync_corr u_corr (
		.core_clk (core_clk),
		.rst      (rst),
		.cif      (cif.corr)
	);

	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	// code mode select
	assign pn_mode = st_reg.mode[mcsync_pkg::MODE_PN_EN]
		& st_reg.mode[mcsync_pkg::MODE_SEL]
		& ~st_reg.mode[mcsync_pkg::MODE_PULSE];
	assign rx_en   = pn_mode & st_reg.timing[mcsync_pkg::TIM_IN_EN];
	assign tx_en   = pn_mode & st_reg.timing[mcsync_pkg::TIM_OUT_EN];

	// sync input is differential; a broken pair (both equal) reads as zero
	assign cif.rx_bit    = sync_in_p & ~sync_in_n;
	assign cif.sample_en = rx_en;
	assign cif.threshold = st_reg.timing[mcsync_pkg::TIM_THR_LSB +: 5];

	// ---------------------------------------------------------------
	// register port decode
	// ---------------------------------------------------------------
	// unmapped addresses fall through and are ignored
	always_comb begin
		wr_mode   = 1'b0;
		wr_timing = 1'b0;
		wr_status = 1'b0;
		if (reg_wr && reg_addr == mcsync_pkg::ADDR_MODE) begin
			wr_mode = 1'b1;
		end else if (reg_wr && reg_addr == mcsync_pkg::ADDR_TIMING) begin
			wr_timing = 1'b1;
		end else if (reg_wr && reg_addr == mcsync_pkg::ADDR_STATUS) begin
			wr_status = 1'b1;
		end
	end

	// status word for fault query
	// lock and lost bits are read only; writes to them are dropped
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[mcsync_pkg::ST_SYNC_EN]  = st_reg.irq_en[0];
		status_word[mcsync_pkg::ST_DATA_EN]  = st_reg.irq_en[1];
		status_word[mcsync_pkg::ST_SYNC_FLG] = st_reg.sync_flag;
		status_word[mcsync_pkg::ST_DATA_FLG] = st_reg.data_flag;
		status_word[mcsync_pkg::ST_LOCK]     = (st_reg.lock == mcsync_pkg::LK_LOCKED);
		status_word[mcsync_pkg::ST_LOST]     = st_reg.lost;
		status_word[mcsync_pkg::ST_CLR_LOCK] = st_reg.clr_lock;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_next      = st_reg;
		st_next.init = 1'b0;

		if (wr_mode) begin
			st_next.mode = reg_wdata;
		end
		if (wr_timing) begin
			st_next.timing = reg_wdata;
		end

		// ---------------------------------------------------------------
		// status register writes
		// ---------------------------------------------------------------
		// per-flag masks
		if (wr_status) begin
			st_next.irq_en   = {reg_wdata[mcsync_pkg::ST_DATA_EN],
				reg_wdata[mcsync_pkg::ST_SYNC_EN]};
			st_next.clr_lock = reg_wdata[mcsync_pkg::ST_CLR_LOCK];
		end

		// flags latch, cleared by writing one
		if (wr_status && reg_wdata[mcsync_pkg::ST_SYNC_FLG]) begin
			st_next.sync_flag = 1'b0;
		end
		if (wr_status && reg_wdata[mcsync_pkg::ST_DATA_FLG]) begin
			st_next.data_flag = 1'b0;
		end
		// a new error in the clearing cycle survives the clear
		if (sync_timing_err) begin
			st_next.sync_flag = 1'b1;
		end
		if (data_timing_err) begin
			st_next.data_flag = 1'b1;
		end

		// clear on falling edge of clear-lock control
		if (wr_status && st_reg.clr_lock && !reg_wdata[mcsync_pkg::ST_CLR_LOCK]) begin
			st_next.lost = 1'b0;
		end

		// ---------------------------------------------------------------
		// master code generator
		// ---------------------------------------------------------------
		// restarts from the first bit on every enable, so peers only see whole codes
		// master code generator
		if (tx_en) begin
			st_next.tx_idx = st_reg.tx_idx + 5'h01;
			st_next.tx_bit = mcsync_pkg::PN_CODE[5'h1F - st_reg.tx_idx];
		end else begin
			st_next.tx_idx = 5'h00;
			st_next.tx_bit = 1'b0;
		end

		// ---------------------------------------------------------------
		// clock machine and accumulator
		// ---------------------------------------------------------------
		// free-running 32-state clock machine
		st_next.clk_state = st_reg.clk_state + 5'h01;
		st_next.nco_acc   = st_reg.nco_acc + nco_step;

		// saturates so a long silence cannot wrap back below the frame length
		if (st_reg.gap_cnt != 6'h3F) begin
			st_next.gap_cnt = st_reg.gap_cnt + 6'h01;
		end

		// ---------------------------------------------------------------
		// lock tracking
		// ---------------------------------------------------------------
		// one missing code drops lock; the threshold already absorbs bit errors
		case (st_reg.lock)
			mcsync_pkg::LK_SEARCH: begin
				if (cif.detect && rx_en) begin
					st_next.lock    = mcsync_pkg::LK_LOCKED;
					st_next.gap_cnt = 6'h01;
					// align both clock state and phase
					st_next.init    = 1'b1;
					// take master phase at code boundary
					// only on acquisition; a reload while locked would jump the phase
					st_next.nco_acc = 32'h0000_0000;
				end
			end
			mcsync_pkg::LK_LOCKED: begin
				if (!rx_en) begin
					st_next.lock = mcsync_pkg::LK_SEARCH;
				end else if (cif.detect) begin
					st_next.gap_cnt = 6'h01;
					st_next.init    = 1'b1;
				end else if (st_reg.gap_cnt >= mcsync_pkg::FRAME_LEN) begin
					// expected code missing: drop lock and remember it
					st_next.lock = mcsync_pkg::LK_SEARCH;
					st_next.lost = 1'b1;
				end
			end
			default: begin
				st_next.lock = mcsync_pkg::LK_SEARCH;
			end
		endcase

		// load clock preset
		// repeated pulses every 32 cycles land on the same state, so a
		// locked device keeps running undisturbed
		if (st_next.init) begin
			st_next.clk_state = {1'b0, st_reg.timing[mcsync_pkg::TIM_CST_LSB +: 4]};
		end

		// ---------------------------------------------------------------
		// interrupt and readback
		// ---------------------------------------------------------------
		// either unmasked flag drives the line
		st_next.irq_oe = (st_next.sync_flag & st_next.irq_en[0])
			| (st_next.data_flag & st_next.irq_en[1]);

		// read data is registered, so it lags the address by one cycle
		if (reg_addr == mcsync_pkg::ADDR_MODE) begin
			st_next.rdata = st_reg.mode;
		end else if (reg_addr == mcsync_pkg::ADDR_TIMING) begin
			st_next.rdata = st_reg.timing;
		end else if (reg_addr == mcsync_pkg::ADDR_STATUS) begin
			st_next.rdata = status_word;
		end else begin
			st_next.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_reg           <= '0;
			st_reg.mode      <= mcsync_pkg::MODE_RST;
			st_reg.timing    <= mcsync_pkg::TIMING_RST;
			st_reg.irq_en    <= mcsync_pkg::IRQ_EN_RST;
			st_reg.lock      <= mcsync_pkg::LK_SEARCH;
		end else begin
			st_reg <= st_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// differential code out
	// gated by the enable so a last one bit cannot linger after the master is turned off
	assign sync_out_p          = st_reg.tx_bit & tx_en;
	assign sync_out_n          = ~st_reg.tx_bit & tx_en;
	assign sync_out_half_delay = st_reg.timing[mcsync_pkg::TIM_OPOL];
	// 80 ps output delay line trim
	assign sync_out_delay_trim = st_reg.timing[mcsync_pkg::TIM_ODLY_LSB +: 5];
	// 80 ps input delay line trim
	assign sync_in_delay_trim  = st_reg.timing[mcsync_pkg::TIM_IDLY_LSB +: 5];
	assign reg_rdata           = st_reg.rdata;
	assign nco_phase           = st_reg.nco_acc;
	assign clk_state           = st_reg.clk_state;
	assign init_pulse          = st_reg.init;
	assign irq_n_o             = 1'b0;
	assign irq_n_oe            = st_reg.irq_oe;

endmodule

// [sim/mcsync_top_asserts.sv]
`timescale 1ns/1ps
module mcsync_top_asserts (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [31:0] reg_rdata,
	input wire logic        data_timing_err,
	input wire logic        sync_timing_err,
	input wire logic        sync_out_p,
	input wire logic        sync_out_n,
	input wire logic        sync_out_half_delay,
	input wire logic [4:0]  sync_out_delay_trim,
	input wire logic [4:0]  sync_in_delay_trim,
	input wire logic [4:0]  clk_state,
	input wire logic        init_pulse,
	input wire logic        irq_n_o,
	input wire logic        irq_n_oe
);
	logic [5:0] since_reg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ------------------------------
	// cycles since last init pulse
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (rst || init_pulse) since_reg <= rst ? 6'h3F : 6'h00;
		else if (since_reg != 6'h3F) since_reg <= since_reg + 6'h01;
	end
	property p_n_excl; (sync_out_p || sync_out_n) |-> sync_out_p != sync_out_n; endproperty
	a_n_excl: assert property (p_n_excl) else $error("sync pair not complementary");
	property p_gap; init_pulse |-> since_reg >= 6'h1F; endproperty
	a_gap: assert property (p_gap) else $error("init pulses closer than 32");
	property p_count; (!rst && !init_pulse) ##1 !init_pulse |-> clk_state == 5'($past(clk_state) + 5'h01); endproperty
	a_count: assert property (p_count) else $error("clock state skipped");
	property p_irq_low; irq_n_oe |-> !irq_n_o; endproperty
	a_irq_low: assert property (p_irq_low) else $error("irq data not low");
	property p_irq; (reg_addr == mcsync_pkg::ADDR_STATUS && !reg_wr && !sync_timing_err
		&& !data_timing_err)[*3] |-> irq_n_oe == |({reg_rdata[7], reg_rdata[6]} & reg_rdata[1:0]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq differs from flags");
	property p_itrim; (!reg_wr)[*2] |=> $stable(sync_in_delay_trim); endproperty
	a_itrim: assert property (p_itrim) else $error("in trim moved");
	property p_otrim; (!reg_wr)[*2] |=> $stable(sync_out_delay_trim); endproperty
	a_otrim: assert property (p_otrim) else $error("out trim moved");
	property p_half; (!reg_wr)[*2] |=> $stable(sync_out_half_delay); endproperty
	a_half: assert property (p_half) else $error("half delay moved");
endmodule
bind mcsync_top mcsync_top_asserts u_mcsync_top_asserts (.core_clk, .rst, .reg_addr, .reg_wr,
	.reg_rdata, .data_timing_err, .sync_timing_err, .sync_out_p, .sync_out_n, .sync_out_half_delay,
	.sync_out_delay_trim, .sync_in_delay_trim, .clk_state, .init_pulse, .irq_n_o, .irq_n_oe);

// [sim/mcsync_peer.sv]
`timescale 1ns/1ps
module mcsync_peer (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       en,
	input  wire logic [5:0] flips,
	output logic            sync_p,
	output logic            sync_n
);
	logic [4:0] idx_reg;
	// -----------------------------
	// remote master code source
	// -----------------------------
	assign sync_n = ~sync_p;
	always_ff @(posedge core_clk) begin
		// idle line toggles so a stale bit can never look like code
		if (rst || !en) begin
			idx_reg <= 5'h00;
			sync_p <= rst ? 1'b0 : ~sync_p;
		end else begin
			sync_p <= mcsync_pkg::PN_CODE[5'h1F - idx_reg] ^ ({1'b0, idx_reg} < flips);
			idx_reg <= idx_reg + 5'h01;
		end
	end
endmodule

// [sim/mcsync_top_tb.sv]
`timescale 1ns/1ps
module mcsync_top_tb;
	logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, loop = 1'b0, p_en = 1'b0;
	logic        sync_timing_err = 1'b0, data_timing_err = 1'b0;
	logic [4:0]  reg_addr = 5'h00, otrim, itrim, clk_state;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, v, nco;
	logic [5:0]  flips = 6'h00;
	logic        peer_p, peer_n, sync_out_p, sync_out_n, init_pulse, irq_n_oe, hd;
	int          err_total = 0, n_compared = 0;
	wire logic   sync_in_p = loop ? sync_out_p : peer_p;
	wire logic   sync_in_n = loop ? sync_out_n : peer_n;
	always #5 core_clk = ~core_clk;
	mcsync_top u_mcsync_top (.core_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
		.sync_in_p, .sync_in_n, .sync_out_p, .sync_out_n, .sync_out_half_delay(hd),
		.sync_out_delay_trim(otrim), .sync_in_delay_trim(itrim), .data_timing_err,
		.sync_timing_err, .nco_step(32'h0001_0000), .nco_phase(nco), .clk_state, .init_pulse,
		.irq_n_o(), .irq_n_oe);
	mcsync_peer u_mcsync_peer (.core_clk, .rst, .en(p_en), .flips, .sync_p(peer_p),
		.sync_n(peer_n));
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [4:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr <= 1'b1;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		tick(3);
		v = reg_rdata;
	endtask
	task automatic wait_pulse(int n, logic e);
		logic f = 1'b0;
		repeat (n) begin
			tick(1);
			if (init_pulse) begin
				f = 1'b1;
				break;
			end
		end
		chk("init_pulse seen", {31'h0, e}, {31'h0, f});
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic t_reset;
		rd(mcsync_pkg::ADDR_TIMING);
		chk("timing", mcsync_pkg::TIMING_RST, v);
		rd(mcsync_pkg::ADDR_STATUS);
		chk("status", 32'h0000_0003, v);
		wr(5'h05, 32'hFFFF_FFFF);
		rd(5'h05);
		chk("unmapped", 32'h0, v);
		wr(mcsync_pkg::ADDR_TIMING, 32'h80A8_5200);
		tick(2);
		chk("in trim", 32'h15, {27'h0, itrim});
		chk("out trim", 32'h0A, {27'h0, otrim});
		chk("half delay", 32'h1, {31'h0, hd});
	endtask
	task automatic t_master;
		logic [31:0] s = 32'h0;
		logic [63:0] dd = {mcsync_pkg::PN_CODE, mcsync_pkg::PN_CODE};
		logic ok = 1'b0;
		wr(mcsync_pkg::ADDR_MODE, 32'h0000_3000);
		wr(mcsync_pkg::ADDR_TIMING, 32'h8600_0450);
		@(posedge core_clk) loop <= 1'b1;
		tick(4);
		for (int i = 0; i < 32; i++) begin
			tick(1);
			s = {s[30:0], sync_out_p};
		end
		for (int r = 0; r < 32; r++) if (dd[63-r -: 32] === s) ok = 1'b1;
		chk("code out", 32'h1, {31'h0, ok});
		wait_pulse(100, 1'b1);
		tick(32);
		chk("repeat pulse", 32'h1, {31'h0, init_pulse});
		chk("preset", 32'h05, {27'h0, clk_state});
		rd(mcsync_pkg::ADDR_STATUS);
		chk("lock", 32'h1, {31'h0, v[10]});
	endtask
	task automatic t_slave;
		wr(mcsync_pkg::ADDR_TIMING, 32'h8400_0450);
		@(posedge core_clk) loop <= 1'b0;
		@(posedge core_clk) p_en <= 1'b1;
		wait_pulse(100, 1'b1);
		chk("nco load", 32'h0, nco);
		chk("slave preset", 32'h05, {27'h0, clk_state});
		chk("slave out", 32'h0, {31'h0, sync_out_p});
		@(posedge core_clk) p_en <= 1'b0;
		tick(40);
		rd(mcsync_pkg::ADDR_STATUS);
		chk("lost", 32'h2, {30'h0, v[11:10]});
		wr(mcsync_pkg::ADDR_STATUS, 32'h0000_1003);
		rd(mcsync_pkg::ADDR_STATUS);
		chk("lost held", 32'h1, {31'h0, v[11]});
		wr(mcsync_pkg::ADDR_STATUS, 32'h0000_0003);
		rd(mcsync_pkg::ADDR_STATUS);
		chk("lost clear", 32'h0, {31'h0, v[11]});
		@(posedge core_clk) flips <= 6'h08;
		@(posedge core_clk) p_en <= 1'b1;
		wait_pulse(100, 1'b0);
		wr(mcsync_pkg::ADDR_TIMING, 32'h7C00_0450);
		wait_pulse(100, 1'b1);
		@(posedge core_clk) p_en <= 1'b0;
	endtask
	task automatic t_irq;
		@(posedge core_clk) sync_timing_err <= 1'b1;
		@(posedge core_clk) sync_timing_err <= 1'b0;
		#1 chk("irq sync", 32'h1, {31'h0, irq_n_oe});
		wr(mcsync_pkg::ADDR_STATUS, 32'h0000_0002);
		tick(1);
		chk("irq masked", 32'h0, {31'h0, irq_n_oe});
		rd(mcsync_pkg::ADDR_STATUS);
		chk("sync flag held", 32'h1, {31'h0, v[6]});
		wr(mcsync_pkg::ADDR_STATUS, 32'h0000_0043);
		tick(1);
		chk("irq clear", 32'h0, {31'h0, irq_n_oe});
		@(posedge core_clk) data_timing_err <= 1'b1;
		@(posedge core_clk) data_timing_err <= 1'b0;
		rd(mcsync_pkg::ADDR_STATUS);
		chk("data flag", 32'h1, {31'h0, v[7] & irq_n_oe});
		wr(mcsync_pkg::ADDR_STATUS, 32'h0000_0083);
		tick(1);
		chk("irq data clear", 32'h0, {31'h0, irq_n_oe});
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		t_reset;
		t_master;
		t_slave;
		t_irq;
		tally_and_finish;
	end
	initial begin
		#200000;
		err_total++;
		tally_and_finish;
	end
endmodule
